// file: src/pfp_fuse_prog.sv
// programming state machine, provisional registers and fuse requests
// Function
// RULE_01: power-up enters initial, clears intact bits
// RULE_02: initial state ignores low pulses
// RULE_03: one high pulse enters mode selection
// RULE_04: low pulse count picks try/blow/lock
// RULE_05: mode counter wraps past lock
// RULE_06: high pulse with zero mode count ignored
// RULE_07: high pulse with valid mode enters register select
// RULE_08: low pulse count picks register, wrapping
// RULE_09: register widths 2,9,2,8,5,2,1 bits
// RULE_10: try mode low pulse increments value immediately
// RULE_11: programmer blows one bitfield per sequence
// RULE_12: try exit keeps values, back to mode
// RULE_13: blow exit blows selected fuse, back to mode
// RULE_14: lock fuse forbids all further programming
// RULE_15: offset coarse decode, wrap past 10
// RULE_16: offset fine codes 0 to 511
// RULE_17: gain coarse decode, wrap past 10
// RULE_18: gain fine codes 0 to 255
// RULE_19: tc 1-11 positive, 16-27 negative steps
// RULE_20: tc codes 12-15, 28-31 alias down
// RULE_21: clamp decode, wrap past code 2
// RULE_22: polarity bit selects positive or negative
// RULE_23: entering bitfield clears selected intact bits
// RULE_24: programmer power-cycles before blow or lock
// RULE_25: lock mode skips register select
// RULE_26: high pulse under 35us strobes, longer blows
// RULE_27: locked device ignores pulses, keeps values
`timescale 1ns/100ps
`default_nettype none

module pfp_fuse_prog (
  input wire logic clk,
  input wire logic resetn,
  input wire logic high_program_pulse,
  input wire logic low_program_pulse,
  input wire pfp_pkg::pfp_cfg_s fuse_blown,
  input wire logic lock_fuse_blown,
  output pfp_pkg::pfp_cfg_s cfg_value,
  output pfp_pkg::pfp_range_e offset_range,
  output pfp_pkg::pfp_range_e gain_range,
  output logic [4:0] tc_code_used,
  output logic signed [4:0] tc_step,
  output pfp_pkg::pfp_clamp_e clamp_mode,
  output logic polarity_negative,
  output pfp_pkg::pfp_state_e prog_state,
  output logic fuse_blow,
  output logic [2:0] fuse_blow_reg,
  output logic [8:0] fuse_blow_mask,
  output logic lock_blow,
  output logic blow_window
);

  // read one register out of the configuration as a 9-bit word
  function automatic logic [8:0] get_field(input pfp_pkg::pfp_cfg_s c, input logic [2:0] idx);
    logic [8:0] v;
    v = 9'h000;
    case (idx)
      pfp_pkg::REG_OFS_C: v = {7'h00, c.offset_coarse_range};
      pfp_pkg::REG_OFS_F: v = c.offset_fine_value;
      pfp_pkg::REG_GAIN_C: v = {7'h00, c.gain_coarse_range};
      pfp_pkg::REG_GAIN_F: v = {1'h0, c.gain_fine_value};
      pfp_pkg::REG_TC: v = {4'h0, c.temp_coefficient_setting};
      pfp_pkg::REG_CLAMP: v = {7'h00, c.output_clamp_level};
      pfp_pkg::REG_POL: v = {8'h00, c.output_polarity};
      default: v = 9'h000;
    endcase
    return v;
  endfunction

  // three-code registers step 0,1,2 then back to 0
  function automatic logic [1:0] inc3(input logic [1:0] v);
    return (v >= pfp_pkg::CODE3_LAST) ? 2'h0 : 2'(v + 2'h1);
  endfunction

  // bump the selected register by one, each in its own wrap
  function automatic pfp_pkg::pfp_cfg_s inc_field(input pfp_pkg::pfp_cfg_s c,
                                                  input logic [2:0] idx);
    pfp_pkg::pfp_cfg_s r;
    r = c;
    case (idx)
      pfp_pkg::REG_OFS_C: r.offset_coarse_range = inc3(c.offset_coarse_range); // see RULE_15
      pfp_pkg::REG_OFS_F: r.offset_fine_value = 9'(c.offset_fine_value + 9'h001); // see RULE_16
      pfp_pkg::REG_GAIN_C: r.gain_coarse_range = inc3(c.gain_coarse_range); // see RULE_17
      pfp_pkg::REG_GAIN_F: r.gain_fine_value = 8'(c.gain_fine_value + 8'h01); // see RULE_18
      pfp_pkg::REG_TC: r.temp_coefficient_setting = 5'(c.temp_coefficient_setting + 5'h01);
      pfp_pkg::REG_CLAMP: r.output_clamp_level = inc3(c.output_clamp_level); // see RULE_21
      pfp_pkg::REG_POL: r.output_polarity = ~c.output_polarity;
      default: r = c;
    endcase
    return r;
  endfunction

  // zero the selected register's provisional bits
  function automatic pfp_pkg::pfp_cfg_s clear_field(input pfp_pkg::pfp_cfg_s c,
                                                    input logic [2:0] idx);
    pfp_pkg::pfp_cfg_s r;
    r = c;
    case (idx)
      pfp_pkg::REG_OFS_C: r.offset_coarse_range = 2'h0;
      pfp_pkg::REG_OFS_F: r.offset_fine_value = 9'h000;
      pfp_pkg::REG_GAIN_C: r.gain_coarse_range = 2'h0;
      pfp_pkg::REG_GAIN_F: r.gain_fine_value = 8'h00;
      pfp_pkg::REG_TC: r.temp_coefficient_setting = 5'h00;
      pfp_pkg::REG_CLAMP: r.output_clamp_level = 2'h0;
      pfp_pkg::REG_POL: r.output_polarity = 1'h0;
      default: r = c;
    endcase
    return r;
  endfunction

  // ---------------- pulse timing ----------------
  logic hi_d; // previous high level
  logic lo_d; // previous low level
  logic hi_act; // a high pulse is being measured
  logic [10:0] hi_cnt; // high pulse length, saturating
  logic [9:0] ext_cnt; // internal extension remaining
  logic [7:0] lo_cnt; // internal low pulse remaining
  logic next_hi_d;
  logic next_lo_d;
  logic next_hi_act;
  logic [10:0] next_hi_cnt;
  logic [9:0] next_ext_cnt;
  logic [7:0] next_lo_cnt;
  logic hi_ev; // high pulse just ended
  logic hi_long; // that pulse reached blowing length
  logic lo_ev; // new low pulse accepted
  logic locked; // lock fuse blown, programming dead

  assign locked = lock_fuse_blown;

  // pulse detection; a new pulse inside an internal pulse merges into it
  always_comb begin
    next_hi_d = high_program_pulse;
    next_lo_d = low_program_pulse;
    next_hi_act = hi_act;
    next_hi_cnt = hi_cnt;
    next_ext_cnt = (ext_cnt != 10'h000) ? 10'(ext_cnt - 10'h001) : ext_cnt;
    next_lo_cnt = (lo_cnt != 8'h00) ? 8'(lo_cnt - 8'h01) : lo_cnt;
    hi_ev = hi_act && hi_d && !high_program_pulse && !locked; // see RULE_27
    hi_long = hi_cnt >= pfp_pkg::LONG_CYC; // see RULE_26
    lo_ev = low_program_pulse && !lo_d && (lo_cnt == 8'h00) && !locked;
    if (!hi_act && high_program_pulse && !hi_d && ext_cnt == 10'h000 && !locked) begin
      // rising edge starts the measurement
      next_hi_act = 1'b1;
      next_hi_cnt = 11'h001;
    end else if (hi_act && high_program_pulse) begin
      // saturate so very long blowing pulses do not wrap
      if (hi_cnt < pfp_pkg::LONG_CYC) begin
        next_hi_cnt = 11'(hi_cnt + 11'h001);
      end
    end else if (hi_ev) begin
      // internal pulse outlives the external one
      next_hi_act = 1'b0;
      next_ext_cnt = pfp_pkg::EXT_CYC; // see RULE_26
    end
    if (lo_ev) begin
      next_lo_cnt = 8'(pfp_pkg::LOW_CYC - 8'h01);
    end
  end

  // timing registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hi_d <= 1'b0;
      lo_d <= 1'b0;
      hi_act <= 1'b0;
      hi_cnt <= 11'h000;
      ext_cnt <= 10'h000;
      lo_cnt <= 8'h00;
    end else begin
      hi_d <= next_hi_d;
      lo_d <= next_lo_d;
      hi_act <= next_hi_act;
      hi_cnt <= next_hi_cnt;
      ext_cnt <= next_ext_cnt;
      lo_cnt <= next_lo_cnt;
    end
  end

  // ---------------- state machine and registers ----------------
  pfp_pkg::pfp_state_e state;
  pfp_pkg::pfp_state_e next_state;
  pfp_pkg::pfp_mode_e mode; // mode latched on leaving mode selection
  pfp_pkg::pfp_mode_e next_mode;
  logic [1:0] mode_cnt; // low pulses seen in mode selection
  logic [1:0] next_mode_cnt;
  logic [2:0] reg_sel; // low pulses seen in register selection
  logic [2:0] next_reg_sel;
  logic lock_set; // lock bit set in bitfield selection
  logic next_lock_set;
  pfp_pkg::pfp_cfg_s prov; // provisional, fuse-less values
  pfp_pkg::pfp_cfg_s next_prov;
  logic next_fuse_blow;
  logic [2:0] next_fuse_blow_reg;
  logic [8:0] next_fuse_blow_mask;
  logic next_lock_blow;
  logic next_blow_window;
  pfp_pkg::pfp_cfg_s eff; // blown fuses read as ones
  logic [4:0] tc_fold;

  // state transitions driven by pulse events
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_mode_cnt = mode_cnt;
    next_reg_sel = reg_sel;
    next_lock_set = lock_set;
    next_prov = prov;
    next_fuse_blow = 1'b0;
    next_fuse_blow_reg = fuse_blow_reg;
    next_fuse_blow_mask = fuse_blow_mask;
    next_lock_blow = 1'b0;
    next_blow_window = blow_window && (ext_cnt > 10'h001);
    // once locked no event ever fires, so values freeze; see RULE_14 RULE_27
    unique case (state)
      pfp_pkg::PFP_ST_INIT: begin
        // low pulses do nothing here; see RULE_02
        if (hi_ev) begin
          next_state = pfp_pkg::PFP_ST_MODE; // see RULE_03
          next_mode_cnt = 2'h0;
        end
      end
      pfp_pkg::PFP_ST_MODE: begin
        if (lo_ev) begin
          // two-bit counter wraps back to no mode; see RULE_04 RULE_05
          next_mode_cnt = 2'(mode_cnt + 2'h1);
        end else if (hi_ev && mode_cnt != 2'h0) begin // see RULE_06
          next_mode = pfp_pkg::pfp_mode_e'(mode_cnt);
          next_reg_sel = 3'h0;
          next_lock_set = 1'b0;
          if (mode_cnt == pfp_pkg::PFP_MODE_LOCK) begin
            next_state = pfp_pkg::PFP_ST_BIT; // see RULE_25
          end else begin
            next_state = pfp_pkg::PFP_ST_REG; // see RULE_07
          end
        end
      end
      pfp_pkg::PFP_ST_REG: begin
        if (lo_ev) begin
          // seven registers, wrapping; see RULE_08
          next_reg_sel = (reg_sel == pfp_pkg::REG_LAST) ? 3'h0 : 3'(reg_sel + 3'h1);
        end else if (hi_ev) begin
          next_prov = clear_field(prov, reg_sel); // see RULE_23
          next_state = pfp_pkg::PFP_ST_BIT;
        end
      end
      pfp_pkg::PFP_ST_BIT: begin
        if (lo_ev) begin
          if (mode == pfp_pkg::PFP_MODE_LOCK) begin
            next_lock_set = 1'b1; // see RULE_25
          end else begin
            // visible on cfg_value two cycles later; see RULE_10
            next_prov = inc_field(prov, reg_sel);
          end
        end else if (hi_ev) begin
          // try values simply stay in place; see RULE_12
          next_state = pfp_pkg::PFP_ST_MODE;
          next_mode_cnt = 2'h0;
          if (hi_long && mode == pfp_pkg::PFP_MODE_BLOW) begin
            // only bits not yet blown; one bit expected; see RULE_13 RULE_11
            next_fuse_blow = 1'b1;
            next_fuse_blow_reg = reg_sel;
            next_fuse_blow_mask = get_field(prov, reg_sel) & ~get_field(fuse_blown, reg_sel);
            next_blow_window = 1'b1;
          end
          if (hi_long && mode == pfp_pkg::PFP_MODE_LOCK && lock_set) begin
            next_lock_blow = 1'b1; // see RULE_14
            next_blow_window = 1'b1;
          end
        end
      end
    endcase
  end

  // effective values and their decodes
  always_comb begin
    eff = prov | fuse_blown; // see RULE_01 RULE_09
    // fold unused tc codes onto used ones; see RULE_20
    if (eff.temp_coefficient_setting[3:2] == 2'b11) begin
      tc_fold = 5'(eff.temp_coefficient_setting - pfp_pkg::TC_ALIAS_SUB);
    end else begin
      tc_fold = eff.temp_coefficient_setting;
    end
  end

  // control and output registers; reset zeroes prov and cfg_value, blown bits return on the first edge after release
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= pfp_pkg::PFP_ST_INIT; // see RULE_01
      mode <= pfp_pkg::PFP_MODE_NONE;
      mode_cnt <= 2'h0;
      reg_sel <= 3'h0;
      lock_set <= 1'b0;
      prov <= pfp_pkg::CFG_RESET;
      fuse_blow <= 1'b0;
      fuse_blow_reg <= 3'h0;
      fuse_blow_mask <= 9'h000;
      lock_blow <= 1'b0;
      blow_window <= 1'b0;
      cfg_value <= pfp_pkg::CFG_RESET;
      offset_range <= pfp_pkg::PFP_RANGE_MID;
      gain_range <= pfp_pkg::PFP_RANGE_LOW;
      tc_code_used <= 5'h00;
      tc_step <= 5'sh00;
      clamp_mode <= pfp_pkg::PFP_CLAMP_NONE;
      polarity_negative <= 1'b0;
      prog_state <= pfp_pkg::PFP_ST_INIT;
    end else begin
      state <= next_state;
      mode <= next_mode;
      mode_cnt <= next_mode_cnt;
      reg_sel <= next_reg_sel;
      lock_set <= next_lock_set;
      prov <= next_prov;
      fuse_blow <= next_fuse_blow;
      fuse_blow_reg <= next_fuse_blow_reg;
      fuse_blow_mask <= next_fuse_blow_mask;
      lock_blow <= next_lock_blow;
      blow_window <= next_blow_window;
      cfg_value <= eff;
      // code 3 reads as the wrapped code 0; see RULE_15 RULE_17
      case (eff.offset_coarse_range)
        2'h1: offset_range <= pfp_pkg::PFP_RANGE_LOW;
        2'h2: offset_range <= pfp_pkg::PFP_RANGE_HIGH;
        default: offset_range <= pfp_pkg::PFP_RANGE_MID;
      endcase
      case (eff.gain_coarse_range)
        2'h1: gain_range <= pfp_pkg::PFP_RANGE_MID;
        2'h2: gain_range <= pfp_pkg::PFP_RANGE_HIGH;
        default: gain_range <= pfp_pkg::PFP_RANGE_LOW;
      endcase
      tc_code_used <= tc_fold;
      // 16 is one step below zero; see RULE_19
      if (tc_fold[4]) begin
        tc_step <= 5'sh00 - signed'(5'(tc_fold - pfp_pkg::TC_NEG_BASE));
      end else begin
        tc_step <= signed'(tc_fold);
      end
      case (eff.output_clamp_level) // see RULE_21
        2'h1: clamp_mode <= pfp_pkg::PFP_CLAMP_HALF;
        2'h2: clamp_mode <= pfp_pkg::PFP_CLAMP_ONE;
        default: clamp_mode <= pfp_pkg::PFP_CLAMP_NONE;
      endcase
      polarity_negative <= eff.output_polarity; // see RULE_22
      prog_state <= next_state;
    end
  end

  // ---------------- checks ----------------
  a_reset_init: assert property (@(posedge clk) $rose(resetn) |-> // see RULE_01
    state == pfp_pkg::PFP_ST_INIT && prov == pfp_pkg::CFG_RESET)
    else $error("state or values not cleared by reset");
  a_init_low_ignored: assert property (@(posedge clk) disable iff (!resetn) // see RULE_02
    state == pfp_pkg::PFP_ST_INIT && lo_ev |=> state == pfp_pkg::PFP_ST_INIT && $stable(prov))
    else $error("low pulse acted in initial state");
  a_init_to_mode: assert property (@(posedge clk) disable iff (!resetn) // see RULE_03
    state == pfp_pkg::PFP_ST_INIT && hi_ev |=> prog_state == pfp_pkg::PFP_ST_MODE)
    else $error("high pulse did not leave initial state");
  a_mode_zero_hold: assert property (@(posedge clk) disable iff (!resetn) // see RULE_06
    state == pfp_pkg::PFP_ST_MODE && hi_ev && mode_cnt == 2'h0 |=>
    state == pfp_pkg::PFP_ST_MODE)
    else $error("high pulse with no mode left mode selection");
  a_mode_to_reg: assert property (@(posedge clk) disable iff (!resetn) // see RULE_07
    state == pfp_pkg::PFP_ST_MODE && hi_ev && !lo_ev && mode_cnt inside {2'h1, 2'h2} |=>
    state == pfp_pkg::PFP_ST_REG && mode == $past(mode_cnt))
    else $error("valid mode did not enter register selection");
  a_lock_skips_reg: assert property (@(posedge clk) disable iff (!resetn) // see RULE_25
    state == pfp_pkg::PFP_ST_MODE && hi_ev && mode_cnt == 2'h3 |=> state == pfp_pkg::PFP_ST_BIT)
    else $error("lock mode did not skip register selection");
  a_entry_clear: assert property (@(posedge clk) disable iff (!resetn) // see RULE_23
    state == pfp_pkg::PFP_ST_REG && hi_ev |=> get_field(prov, reg_sel) == 9'h000)
    else $error("selected register not cleared on entry");
  a_try_increment: assert property (@(posedge clk) disable iff (!resetn) // see RULE_10
    state == pfp_pkg::PFP_ST_BIT && mode == pfp_pkg::PFP_MODE_TRY && lo_ev &&
    reg_sel == pfp_pkg::REG_OFS_F |=> ##1
    cfg_value.offset_fine_value == ($past(prov.offset_fine_value, 2) + 9'h001 |
    fuse_blown.offset_fine_value))
    else $error("fine offset did not step by one");
  a_coarse_wrap: assert property (@(posedge clk) disable iff (!resetn) // see RULE_15
    state == pfp_pkg::PFP_ST_BIT && lo_ev && mode == pfp_pkg::PFP_MODE_TRY &&
    reg_sel == pfp_pkg::REG_OFS_C && prov.offset_coarse_range == 2'h2 |=>
    prov.offset_coarse_range == 2'h0)
    else $error("coarse offset did not wrap to zero");
  a_blow_on_long: assert property (@(posedge clk) disable iff (!resetn) // see RULE_13
    state == pfp_pkg::PFP_ST_BIT && hi_ev && hi_long && mode == pfp_pkg::PFP_MODE_BLOW |=>
    fuse_blow && blow_window && state == pfp_pkg::PFP_ST_MODE ##1 !fuse_blow)
    else $error("long exit pulse did not blow once");
  a_short_no_blow: assert property (@(posedge clk) disable iff (!resetn) // see RULE_26
    hi_ev && !hi_long |=> !fuse_blow && !lock_blow)
    else $error("short pulse blew a fuse");
  a_locked_frozen: assert property (@(posedge clk) disable iff (!resetn) // see RULE_27
    locked && $past(locked) |=> $stable(prov) && $stable(state))
    else $error("locked device changed state");
  a_tc_alias: assert property (@(posedge clk) disable iff (!resetn) // see RULE_20
    tc_code_used[3:2] != 2'b11)
    else $error("unused tc code reached the output");

endmodule

`default_nettype wire

// file: src/pfp_pkg.sv
// constants, states and field layouts of the pulse-coded fuse programmer
package pfp_pkg;
  // clock rate and pulse timing
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned T_LONG_NS = 35000; // shortest fuse-blowing high pulse
  localparam int unsigned T_EXT_NS = 15000; // internal extension after a high pulse
  localparam int unsigned T_LOW_NS = 5000; // internal low pulse length
  // least time rounds up, extension and low pulse are fixed spans rounded down
  localparam int unsigned LONG_CYC_I = (T_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned EXT_CYC_I = (T_EXT_NS * CLK_MHZ) / 1000;
  localparam int unsigned LOW_CYC_I = (T_LOW_NS * CLK_MHZ) / 1000;
  localparam logic [10:0] LONG_CYC = 11'(LONG_CYC_I);
  localparam logic [9:0] EXT_CYC = 10'(EXT_CYC_I);
  localparam logic [7:0] LOW_CYC = 8'(LOW_CYC_I);

  // register selection codes, in pulse-count order
  localparam logic [2:0] REG_OFS_C = 3'h0;
  localparam logic [2:0] REG_OFS_F = 3'h1;
  localparam logic [2:0] REG_GAIN_C = 3'h2;
  localparam logic [2:0] REG_GAIN_F = 3'h3;
  localparam logic [2:0] REG_TC = 3'h4;
  localparam logic [2:0] REG_CLAMP = 3'h5;
  localparam logic [2:0] REG_POL = 3'h6;
  localparam logic [2:0] REG_LAST = 3'h6;

  // coarse and clamp codes wrap after this one
  localparam logic [1:0] CODE3_LAST = 2'h2;
  // tc alias: codes with bits 3:2 set fold down by this amount
  localparam logic [4:0] TC_ALIAS_SUB = 5'h08;
  localparam logic [4:0] TC_NEG_BASE = 5'h0f;

  // programming states
  typedef enum logic [1:0] {
    PFP_ST_INIT = 2'b00,
    PFP_ST_MODE = 2'b01,
    PFP_ST_REG = 2'b10,
    PFP_ST_BIT = 2'b11
  } pfp_state_e;

  // modes, coded as the low pulse count
  typedef enum logic [1:0] {
    PFP_MODE_NONE = 2'b00,
    PFP_MODE_TRY = 2'b01,
    PFP_MODE_BLOW = 2'b10,
    PFP_MODE_LOCK = 2'b11
  } pfp_mode_e;

  // decoded coarse range
  typedef enum logic [1:0] {
    PFP_RANGE_LOW = 2'b00,
    PFP_RANGE_MID = 2'b01,
    PFP_RANGE_HIGH = 2'b10
  } pfp_range_e;

  // decoded clamp setting
  typedef enum logic [1:0] {
    PFP_CLAMP_NONE = 2'b00,
    PFP_CLAMP_HALF = 2'b01,
    PFP_CLAMP_ONE = 2'b10
  } pfp_clamp_e;

  // all configuration registers, one field each
  typedef struct packed {
    logic [1:0] offset_coarse_range;
    logic [8:0] offset_fine_value;
    logic [1:0] gain_coarse_range;
    logic [7:0] gain_fine_value;
    logic [4:0] temp_coefficient_setting;
    logic [1:0] output_clamp_level;
    logic output_polarity;
  } pfp_cfg_s;

  localparam pfp_cfg_s CFG_RESET = '0;
endpackage

// file: bench/pfp_programmer_model.sv
// model of the external programmer that drives coded pulses onto the pin
`timescale 1ns/100ps
`default_nettype none

module pfp_programmer_model (
  input wire logic clk,
  output var logic high_program_pulse,
  output var logic low_program_pulse
);
  // both levels idle at the neutral level from time zero
  initial begin
    high_program_pulse = 1'b0;
    low_program_pulse = 1'b0;
  end

  // one high pulse of n cycles; exactly one per state step
  // the wait after it covers the internal extension plus a guard band
  task automatic hp(input int n);
    @(posedge clk);
    #1 high_program_pulse = 1'b1;
    repeat (n) @(posedge clk);
    #1 high_program_pulse = 1'b0;
    repeat (1000) @(posedge clk);
  endtask

  // n low pulses, each held past the internal low pulse length
  // a release before the internal pulse ends would leave the count undefined
  // a blow sequence always counts toward a single bitfield
  task automatic lp(input int n);
    repeat (n) begin
      @(posedge clk);
      #1 low_program_pulse = 1'b1;
      repeat (300) @(posedge clk);
      #1 low_program_pulse = 1'b0;
      repeat (10) @(posedge clk);
    end
  endtask
endmodule

`default_nettype wire

// file: bench/test_pfp_fuse_prog.sv
// self-checking bench for the pulse-coded fuse programmer
`timescale 1ns/100ps
`default_nettype none

module test_pfp_fuse_prog;
  logic clk; // 50 mhz clock
  logic resetn; // stands for power-up
  logic high_program_pulse;
  logic low_program_pulse;
  pfp_pkg::pfp_cfg_s fuse_blown = '0; // fuse array, burnt by blow requests
  logic lock_fuse_blown = 1'b0; // lock fuse, burnt by the lock request
  pfp_pkg::pfp_cfg_s cfg_value;
  pfp_pkg::pfp_range_e offset_range;
  pfp_pkg::pfp_range_e gain_range;
  logic [4:0] tc_code_used;
  logic signed [4:0] tc_step;
  pfp_pkg::pfp_clamp_e clamp_mode;
  logic polarity_negative;
  pfp_pkg::pfp_state_e prog_state;
  logic fuse_blow;
  logic [2:0] fuse_blow_reg;
  logic [8:0] fuse_blow_mask;
  logic lock_blow;
  logic blow_window;
  int bad_count = 0; // mismatches
  int checks_done = 0; // comparisons made
  int blows = 0; // fuse blow requests seen
  int locks = 0; // lock blow requests seen
  int win = 0; // cycles with the blow window up

  pfp_fuse_prog i_pfp_fuse_prog (.clk(clk), .resetn(resetn),
    .high_program_pulse(high_program_pulse), .low_program_pulse(low_program_pulse),
    .fuse_blown(fuse_blown), .lock_fuse_blown(lock_fuse_blown), .cfg_value(cfg_value),
    .offset_range(offset_range), .gain_range(gain_range), .tc_code_used(tc_code_used),
    .tc_step(tc_step), .clamp_mode(clamp_mode), .polarity_negative(polarity_negative),
    .prog_state(prog_state), .fuse_blow(fuse_blow), .fuse_blow_reg(fuse_blow_reg),
    .fuse_blow_mask(fuse_blow_mask), .lock_blow(lock_blow), .blow_window(blow_window));

  pfp_programmer_model i_pfp_programmer_model (.clk(clk),
    .high_program_pulse(high_program_pulse), .low_program_pulse(low_program_pulse));

  // free-running clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // put a blow mask into the field that it names
  function automatic pfp_pkg::pfp_cfg_s place(input logic [2:0] r, input logic [8:0] m);
    place = '0;
    case (r)
      pfp_pkg::REG_OFS_C: place.offset_coarse_range = m[1:0];
      pfp_pkg::REG_OFS_F: place.offset_fine_value = m;
      pfp_pkg::REG_GAIN_C: place.gain_coarse_range = m[1:0];
      pfp_pkg::REG_GAIN_F: place.gain_fine_value = m[7:0];
      pfp_pkg::REG_TC: place.temp_coefficient_setting = m[4:0];
      pfp_pkg::REG_CLAMP: place.output_clamp_level = m[1:0];
      default: place.output_polarity = m[0];
    endcase
  endfunction

  // fuse array; blow requests last one cycle, so they are counted on every edge
  always @(posedge clk) begin
    if (fuse_blow === 1'b1) begin
      blows <= blows + 1;
      fuse_blown <= fuse_blown | place(fuse_blow_reg, fuse_blow_mask);
    end
    if (lock_blow === 1'b1) begin
      locks <= locks + 1;
      lock_fuse_blown <= 1'b1;
    end
    if (blow_window === 1'b1) win <= win + 1;
  end

  // compare one value, report at once on mismatch
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // power cycle: reset held 8 cycles, then let cfg settle past its lag
  task automatic power_cycle;
    @(posedge clk);
    #1 resetn = 1'b0;
    repeat (8) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // verdict, reached from the tests and from the watchdog
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // watchdog: the tests need about 48k cycles
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    final_report;
  end

  initial begin
    resetn = 1'b0;
    power_cycle;
    chk("state", pfp_pkg::PFP_ST_INIT, prog_state);
    chk("cfg", 32'h0000_0000, cfg_value);
    chk("gain_range", pfp_pkg::PFP_RANGE_LOW, gain_range);
    chk("polarity", 32'h0000_0000, polarity_negative);
    // try value walk through the tc and clamp registers
    i_pfp_programmer_model.lp(2);
    chk("state", pfp_pkg::PFP_ST_INIT, prog_state);
    i_pfp_programmer_model.hp(20);
    chk("state", pfp_pkg::PFP_ST_MODE, prog_state);
    i_pfp_programmer_model.hp(20);
    chk("state", pfp_pkg::PFP_ST_MODE, prog_state);
    i_pfp_programmer_model.lp(5); // wraps round to try value
    i_pfp_programmer_model.hp(20);
    chk("state", pfp_pkg::PFP_ST_REG, prog_state);
    i_pfp_programmer_model.lp(4);
    i_pfp_programmer_model.hp(20);
    chk("state", pfp_pkg::PFP_ST_BIT, prog_state);
    i_pfp_programmer_model.lp(5);
    chk("tc", 32'h0000_0005, cfg_value.temp_coefficient_setting);
    chk("tc_step", 32'h0000_0005, {27'h0, tc_step});
    i_pfp_programmer_model.lp(8);
    chk("tc_used", 32'h0000_0005, tc_code_used);
    i_pfp_programmer_model.lp(3);
    chk("tc_step", 32'h0000_001f, {27'h0, tc_step});
    i_pfp_programmer_model.hp(20);
    chk("state", pfp_pkg::PFP_ST_MODE, prog_state);
    chk("tc", 32'h0000_0010, cfg_value.temp_coefficient_setting);
    i_pfp_programmer_model.lp(1);
    i_pfp_programmer_model.hp(20);
    i_pfp_programmer_model.lp(5);
    i_pfp_programmer_model.hp(20);
    i_pfp_programmer_model.lp(2);
    chk("clamp", pfp_pkg::PFP_CLAMP_ONE, clamp_mode);
    i_pfp_programmer_model.lp(1);
    chk("clamp", 32'h0000_0000, cfg_value.output_clamp_level);
    i_pfp_programmer_model.hp(20);
    i_pfp_programmer_model.lp(1);
    i_pfp_programmer_model.hp(20);
    i_pfp_programmer_model.lp(4);
    i_pfp_programmer_model.hp(20);
    chk("tc", 32'h0000_0000, cfg_value.temp_coefficient_setting);
    // offset coarse wrap and fine offset steps, still in try mode
    i_pfp_programmer_model.hp(20);
    i_pfp_programmer_model.lp(1);
    i_pfp_programmer_model.hp(20);
    i_pfp_programmer_model.hp(20);
    i_pfp_programmer_model.lp(2);
    chk("ofs_range", pfp_pkg::PFP_RANGE_HIGH, offset_range);
    i_pfp_programmer_model.lp(1);
    chk("ofs", 32'h0000_0000, cfg_value.offset_coarse_range);
    i_pfp_programmer_model.hp(20);
    i_pfp_programmer_model.lp(1);
    i_pfp_programmer_model.hp(20);
    i_pfp_programmer_model.lp(1);
    i_pfp_programmer_model.hp(20);
    i_pfp_programmer_model.lp(3);
    chk("ofs_fine", 32'h0000_0003, cfg_value.offset_fine_value);
    $display("try value test done");
    // blow bit 1 of the offset coarse range, power cycle before it
    power_cycle;
    i_pfp_programmer_model.hp(20);
    i_pfp_programmer_model.lp(2);
    i_pfp_programmer_model.hp(20);
    i_pfp_programmer_model.hp(20);
    i_pfp_programmer_model.lp(2);
    i_pfp_programmer_model.hp(1800);
    chk("blows", 32'h0000_0001, blows);
    chk("blow_reg", pfp_pkg::REG_OFS_C, fuse_blow_reg);
    chk("blow_mask", 32'h0000_0002, fuse_blow_mask);
    chk("state", pfp_pkg::PFP_ST_MODE, prog_state);
    chk("window", 32'h0000_02ee, win);
    power_cycle;
    chk("ofs", 32'h0000_0002, cfg_value.offset_coarse_range);
    chk("ofs_range", pfp_pkg::PFP_RANGE_HIGH, offset_range);
    $display("blow fuse test done");
    // lock the device, then confirm that pulses no longer act
    i_pfp_programmer_model.hp(20);
    i_pfp_programmer_model.lp(3);
    i_pfp_programmer_model.hp(20);
    chk("state", pfp_pkg::PFP_ST_BIT, prog_state);
    i_pfp_programmer_model.lp(1);
    i_pfp_programmer_model.hp(1800);
    chk("locks", 32'h0000_0001, locks);
    i_pfp_programmer_model.hp(20);
    i_pfp_programmer_model.lp(3);
    i_pfp_programmer_model.hp(20);
    chk("state", pfp_pkg::PFP_ST_MODE, prog_state);
    chk("ofs", 32'h0000_0002, cfg_value.offset_coarse_range);
    chk("blows", 32'h0000_0001, blows);
    $display("lock test done");
    final_report;
  end
endmodule

`default_nettype wire
